// *** tb/afe_cpu_model.sv ***
// CPU side of the register data bus
`timescale 1ns/10ps
`default_nettype none
module afe_cpu_model (
   // Clock
   input wire logic i_mclk,
   // Register bus
   output logic [3:0] o_addr,
   output logic o_wr,
   output logic [7:0] o_wdata,
   input wire logic [7:0] i_rdata
);
   initial begin
      o_addr = 4'h0;
      o_wr = 1'b0;
      o_wdata = 8'h00;
   end

   // One write strobe cycle
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_mclk);
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask

   // Read data is registered one cycle after the address
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(negedge i_mclk);
      o_addr = a;
      @(negedge i_mclk);
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// *** tb/afe_flow_ctrl_tb_top.sv ***
// Self-checking bench for the error flag and flow control block
`timescale 1ns/10ps
`default_nettype none
module afe_flow_ctrl_tb_top;
   logic clk, rst, en, mode;
   logic [11:0] stim;
   logic [3:0] addr;
   logic wr;
   logic [7:0] wdata, rdata, outs;
   logic [2:0] flow;
   int fail_count, checked, cycles;
   logic [7:0] sev_exp [5] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h20};

   afe_cpu_model CPU (.i_mclk(clk), .o_addr(addr), .o_wr(wr), .o_wdata(wdata), .i_rdata(rdata));

   afe_flow_ctrl DUT (
      .i_mclk(clk), .i_reset(rst), .i_module_enable(en), .i_soft_reset_bit(stim[11]),
      .i_trigger_mode(mode), .i_addr(addr), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata),
      .i_restart_request_bit(stim[0]), .i_trigger_bit(stim[1]),
      .i_sequence_abort_bit(stim[2]), .i_load_ok_bit(stim[3]),
      .i_result_store_fault(stim[4]), .i_fetch_out_of_range(stim[5]),
      .i_command_reserved(stim[6]), .i_resolution_reserved(stim[7]),
      .i_missing_end_of_list(stim[8]), .i_sampling_start(flow[0]), .i_sequence_done(flow[1]),
      .i_end_of_list_flag(flow[2]), .i_abort_done(stim[9]), .i_completion_overrun(stim[10]),
      .o_error_irq(outs[7]), .o_abort_done_irq(outs[6]), .o_overrun_irq(outs[5]),
      .o_abort_conversion(outs[4]), .o_load_first_command(outs[3]), .o_swap_list(outs[2]),
      .o_start_sequence(outs[1]), .o_halted(outs[0]));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle pulse; the registered answer is visible on return
   task automatic pulse(input logic [11:0] v);
      @(negedge clk);
      stim = v;
      @(negedge clk);
      stim = 12'h000;
   endtask

   // One-cycle pulse of the sequencer status inputs together with requests
   task automatic flow_pulse(input logic [2:0] f, input logic [11:0] v);
      @(negedge clk);
      flow = f;
      stim = v;
      @(negedge clk);
      flow = 3'h0;
      stim = 12'h000;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] r;
      CPU.rd_reg(a, r);
      chk(r & m, exp);
   endtask

   task automatic print_verdict();
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1; en = 1'b1; mode = 1'b0; stim = 12'h000;
      flow = 3'h0;
      fail_count = 0; checked = 0; cycles = 0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      rd_chk(4'h6, 8'hFF, 8'h00);
      rd_chk(4'h7, 8'hFF, 8'h00);
      rd_chk(4'h8, 8'hFF, 8'h00);
      rd_chk(4'h0, 8'hFF, 8'h00);
      CPU.wr_reg(4'h6, 8'hFF);
      rd_chk(4'h6, 8'hFF, 8'hEE);
      CPU.wr_reg(4'h7, 8'hFF);
      rd_chk(4'h7, 8'hFF, 8'hC0);
      CPU.wr_reg(4'h6, 8'h08);
      pulse(12'h200);
      chk(outs, 8'h40);
      pulse(12'h400);
      chk(outs, 8'h20);
      CPU.wr_reg(4'h7, 8'h00);
      pulse(12'h600);
      chk(outs, 8'h00);
      // Restart mode: restart without load-OK
      pulse(12'h001);
      chk(outs, 8'h08);
      rd_chk(4'h8, 8'hFF, 8'h02);
      CPU.wr_reg(4'h8, 8'h00);
      rd_chk(4'h8, 8'hFF, 8'h02);
      CPU.wr_reg(4'h8, 8'h02);
      rd_chk(4'h8, 8'h02, 8'h00);
      pulse(12'h009);
      chk(outs, 8'h0C);
      pulse(12'h004);
      chk(outs & 8'h10, 8'h10);
      pulse(12'h800);
      repeat (2) @(negedge clk);
      // Restart with trigger in restart mode is a severe error
      pulse(12'h003);
      @(negedge clk);
      chk(outs & 8'h81, 8'h81);
      rd_chk(4'h8, 8'h08, 8'h08);
      CPU.wr_reg(4'h8, 8'hFF);
      rd_chk(4'h8, 8'hFF, 8'h08);
      pulse(12'h001);
      chk(outs, 8'h81);
      pulse(12'h800);
      @(negedge clk);
      chk(outs, 8'h00);
      rd_chk(4'h8, 8'hFF, 8'h00);
      for (int i = 0; i < 5; i++) begin
         pulse(12'h010 << i);
         @(negedge clk);
         chk(outs, 8'h01);
         rd_chk(4'h8, 8'hFF, sev_exp[i]);
         pulse(12'h800);
         @(negedge clk);
      end
      pulse(12'h010);
      en = 1'b0;
      repeat (2) @(negedge clk);
      rd_chk(4'h8, 8'hFF, 8'h00);
      chk(outs, 8'h00);
      en = 1'b1;
      // Trigger mode: restart starts the sequence by itself
      mode = 1'b1;
      pulse(12'h800);
      repeat (2) @(negedge clk);
      pulse(12'h001);
      chk(outs, 8'h08);
      @(negedge clk);
      chk(outs, 8'h02);
      rd_chk(4'h8, 8'hFF, 8'h00);
      pulse(12'h001);
      rd_chk(4'h8, 8'h04, 8'h04);
      // Sampling begun and sequence done: a later trigger is legal
      flow_pulse(3'h3, 12'h000);
      pulse(12'h002);
      chk(outs, 8'h02);
      rd_chk(4'h8, 8'h08, 8'h00);
      CPU.wr_reg(4'h8, 8'h04);
      rd_chk(4'h8, 8'hFF, 8'h00);
      // Restart once the end of list is reached is no error
      flow_pulse(3'h4, 12'h001);
      chk(outs, 8'h08);
      rd_chk(4'h8, 8'hFF, 8'h00);
      pulse(12'h002);
      @(negedge clk);
      rd_chk(4'h8, 8'h08, 8'h08);
      print_verdict();
   end
endmodule
`default_nettype wire

// *** verilog/afe_flow_ctrl.sv ***
// Error flags, interrupt enables and flow control bit handling
`timescale 1ns/10ps
`default_nettype none
module afe_flow_ctrl (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_reset,
   // Module control
   input wire logic i_module_enable,
   input wire logic i_soft_reset_bit,
   input wire logic i_trigger_mode,
   // Register access
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   // Flow control requests, data bus or internal interface
   input wire logic i_restart_request_bit,
   input wire logic i_trigger_bit,
   input wire logic i_sequence_abort_bit,
   input wire logic i_load_ok_bit,
   // Error events, sequencer status and interrupt events from the datapath
   input wire logic i_result_store_fault,
   input wire logic i_fetch_out_of_range,
   input wire logic i_command_reserved,
   input wire logic i_resolution_reserved,
   input wire logic i_missing_end_of_list,
   input wire logic i_sampling_start,
   input wire logic i_sequence_done,
   input wire logic i_end_of_list_flag,
   input wire logic i_abort_done,
   input wire logic i_completion_overrun,
   // Outputs
   output logic o_error_irq,
   output logic o_abort_done_irq,
   output logic o_overrun_irq,
   output logic o_abort_conversion,
   output logic o_load_first_command,
   output logic o_swap_list,
   output logic o_start_sequence,
   output logic o_halted
);
   typedef struct packed {
      logic [7:0] err_ie;
      logic [7:0] ie;
      logic [7:0] err_flags;
      logic [7:0] rdata;
      afe_pkg::afe_state_t state;
      logic sampling;
      logic error_irq;
      logic abort_done_irq;
      logic overrun_irq;
      logic abort_conv;
      logic load_first;
      logic swap;
      logic start_seq;
      logic halted;
   } afe_state_s_t;

   afe_state_s_t s_reg;
   afe_state_s_t s_next;
   logic trigger_bit_eff;
   logic [7:0] set_ev;

   always_comb begin
      s_next = s_reg;
      set_ev = afe_pkg::RESET_BYTE;
      s_next.abort_conv = 1'b0;
      s_next.load_first = 1'b0;
      s_next.swap = 1'b0;
      s_next.start_seq = 1'b0;
      trigger_bit_eff = i_trigger_bit | (i_trigger_mode & i_restart_request_bit);
      // Register writes
      if (i_wr) begin
         if (i_addr == afe_pkg::OFF_ERR_IE) begin
            s_next.err_ie = i_wdata & afe_pkg::ERR_IE_MASK;
         end else if (i_addr == afe_pkg::OFF_IE) begin
            s_next.ie = i_wdata & afe_pkg::IE_MASK;
         end else if (i_addr == afe_pkg::OFF_ERR_FLAGS) begin
            s_next.err_flags = s_reg.err_flags & ~(i_wdata & afe_pkg::CLEARABLE_MASK);
         end
      end
      set_ev[afe_pkg::BIT_IA] = i_result_store_fault | i_fetch_out_of_range;
      set_ev[afe_pkg::BIT_CMD] = i_command_reserved | i_resolution_reserved;
      set_ev[afe_pkg::BIT_EOL] = i_missing_end_of_list;
      set_ev[afe_pkg::BIT_TRIGGER_BIT] =
         (!i_trigger_mode & i_restart_request_bit & i_trigger_bit) |
         (i_trigger_bit & (s_reg.state == afe_pkg::AFE_LOAD)) |
         (i_trigger_bit & s_reg.sampling) |
         (i_trigger_mode & i_restart_request_bit & i_trigger_bit) |
         (i_trigger_bit & !i_restart_request_bit & (s_reg.state == afe_pkg::AFE_RUN)
            & !i_sequence_done);
      set_ev[afe_pkg::BIT_RSTAR] = i_restart_request_bit & (s_reg.state == afe_pkg::AFE_RUN)
         & !i_end_of_list_flag & !i_sequence_abort_bit;
      // Load-OK error in restart mode without load-OK
      set_ev[afe_pkg::BIT_LOAD_OK_BIT] = !i_trigger_mode & i_restart_request_bit & !i_load_ok_bit
         & !i_sequence_abort_bit;
      if (s_reg.halted) begin
         set_ev = set_ev & afe_pkg::SEVERE_MASK;
      end
      // Set wins over clear
      s_next.err_flags = s_next.err_flags | set_ev;
      // Sampling tracking and sequencer
      if (i_sampling_start) begin
         s_next.sampling = 1'b0;
      end
      case (s_reg.state)
         afe_pkg::AFE_IDLE: begin
            if (trigger_bit_eff & !i_restart_request_bit) begin
               s_next.state = afe_pkg::AFE_RUN;
               s_next.start_seq = 1'b1;
               s_next.sampling = 1'b1;
            end
         end
         afe_pkg::AFE_LOAD: begin
            if (trigger_bit_eff | i_trigger_mode) begin
               s_next.state = afe_pkg::AFE_RUN;
               s_next.start_seq = 1'b1;
               s_next.sampling = 1'b1;
            end else begin
               s_next.state = afe_pkg::AFE_IDLE;
            end
         end
         afe_pkg::AFE_RUN: begin
            if (i_sequence_done) begin
               s_next.state = afe_pkg::AFE_IDLE;
            end
         end
         default: begin
            s_next.state = afe_pkg::AFE_HALT;
         end
      endcase
      if (i_sequence_abort_bit & !s_reg.halted) begin
         s_next.abort_conv = 1'b1;
         s_next.state = afe_pkg::AFE_IDLE;
         s_next.sampling = 1'b0;
      end
      if (i_restart_request_bit & !s_reg.halted & !set_ev[afe_pkg::BIT_TRIGGER_BIT]) begin
         s_next.load_first = 1'b1;
         s_next.swap = i_load_ok_bit;
         s_next.state = afe_pkg::AFE_LOAD;
      end
      if ((s_next.err_flags & afe_pkg::SEVERE_MASK) != afe_pkg::RESET_BYTE) begin
         s_next.state = afe_pkg::AFE_HALT;
         s_next.halted = 1'b1;
         s_next.start_seq = 1'b0;
         s_next.load_first = 1'b0;
         s_next.swap = 1'b0;
         s_next.sampling = 1'b0;
      end
      if (i_soft_reset_bit) begin
         s_next.err_flags = afe_pkg::RESET_BYTE;
         s_next.state = afe_pkg::AFE_IDLE;
         s_next.halted = 1'b0;
         s_next.sampling = 1'b0;
         s_next.abort_conv = 1'b1;
         s_next.load_first = 1'b0;
         s_next.swap = 1'b0;
         s_next.start_seq = 1'b0;
      end
      if (!i_module_enable) begin
         s_next.err_flags = afe_pkg::RESET_BYTE;
         s_next.state = afe_pkg::AFE_IDLE;
         s_next.halted = 1'b0;
         s_next.sampling = 1'b0;
         s_next.load_first = 1'b0;
         s_next.swap = 1'b0;
         s_next.start_seq = 1'b0;
      end
      s_next.error_irq = |(s_next.err_flags & s_next.err_ie);
      s_next.abort_done_irq = i_abort_done & s_next.ie[afe_pkg::BIT_ABORT_DONE_IE];
      s_next.overrun_irq = i_completion_overrun & s_next.ie[afe_pkg::BIT_OVERRUN_IE];
      // Read data
      if (i_addr == afe_pkg::OFF_ERR_IE) begin
         s_next.rdata = s_next.err_ie;
      end else if (i_addr == afe_pkg::OFF_IE) begin
         s_next.rdata = s_next.ie;
      end else if (i_addr == afe_pkg::OFF_ERR_FLAGS) begin
         s_next.rdata = s_next.err_flags;
      end else begin
         s_next.rdata = afe_pkg::RESET_BYTE;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_rdata = s_reg.rdata;
   assign o_error_irq = s_reg.error_irq;
   assign o_abort_done_irq = s_reg.abort_done_irq;
   assign o_overrun_irq = s_reg.overrun_irq;
   assign o_abort_conversion = s_reg.abort_conv;
   assign o_load_first_command = s_reg.load_first;
   assign o_swap_list = s_reg.swap;
   assign o_start_sequence = s_reg.start_seq;
   assign o_halted = s_reg.halted;

   restart_trigger_bit_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !i_soft_reset_bit && !i_trigger_mode && i_restart_request_bit
       && i_trigger_bit) |=> s_reg.err_flags[afe_pkg::BIT_TRIGGER_BIT])
      else $error("restart with trigger did not flag error");
   abort_pulse_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !o_halted && i_sequence_abort_bit) |=> o_abort_conversion)
      else $error("abort not issued");
   swap_load_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_swap_list |-> o_load_first_command)
      else $error("swap without command load");
   trigger_bit_mode_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_load_first_command && i_trigger_mode && !i_trigger_bit && !i_sequence_abort_bit
       && i_module_enable && !i_soft_reset_bit && !o_halted
       && !i_result_store_fault && !i_fetch_out_of_range && !i_command_reserved
       && !i_resolution_reserved && !i_missing_end_of_list && !i_restart_request_bit)
      |=> o_start_sequence)
      else $error("trigger mode restart did not start sequence");
   halt_quiet_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_halted |-> !o_start_sequence && !o_load_first_command)
      else $error("activity while halted");
   severe_hold_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (s_reg.err_flags[afe_pkg::BIT_IA] && i_module_enable && !i_soft_reset_bit)
      |=> s_reg.err_flags[afe_pkg::BIT_IA])
      else $error("severe flag cleared without soft reset");
   w1c_clear_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_addr == afe_pkg::OFF_ERR_FLAGS && i_wdata[afe_pkg::BIT_LOAD_OK_BIT]
       && !i_restart_request_bit) |=> !s_reg.err_flags[afe_pkg::BIT_LOAD_OK_BIT])
      else $error("load-OK error not cleared by write");
   disable_clear_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      !i_module_enable |=> s_reg.err_flags == afe_pkg::RESET_BYTE)
      else $error("flags not clear while disabled");
   err_irq_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      o_error_irq == |(s_reg.err_flags & s_reg.err_ie))
      else $error("error interrupt mismatch");
   ia_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !i_soft_reset_bit && (i_result_store_fault || i_fetch_out_of_range))
      |=> s_reg.err_flags[afe_pkg::BIT_IA] && o_halted)
      else $error("illegal access did not set its flag");
   cmd_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !i_soft_reset_bit && (i_command_reserved || i_resolution_reserved))
      |=> s_reg.err_flags[afe_pkg::BIT_CMD] && o_halted)
      else $error("bad command value did not set its flag");
   eol_flag_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !i_soft_reset_bit && i_missing_end_of_list)
      |=> s_reg.err_flags[afe_pkg::BIT_EOL] && o_halted)
      else $error("missing end of list did not set its flag");
   trigger_bit_sampling_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !i_soft_reset_bit && i_trigger_bit && s_reg.sampling)
      |=> s_reg.err_flags[afe_pkg::BIT_TRIGGER_BIT] && o_halted)
      else $error("trigger during sampling start not flagged");
   restart_err_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !i_soft_reset_bit && !o_halted && i_restart_request_bit
       && s_reg.state == afe_pkg::AFE_RUN && !i_end_of_list_flag && !i_sequence_abort_bit)
      |=> s_reg.err_flags[afe_pkg::BIT_RSTAR])
      else $error("restart during sequence not flagged");
   severe_write_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_addr == afe_pkg::OFF_ERR_FLAGS && i_module_enable && !i_soft_reset_bit
       && !i_trigger_bit && !i_result_store_fault && !i_fetch_out_of_range
       && !i_command_reserved && !i_resolution_reserved && !i_missing_end_of_list)
      |=> ((s_reg.err_flags & afe_pkg::SEVERE_MASK)
           == ($past(s_reg.err_flags) & afe_pkg::SEVERE_MASK)))
      else $error("write changed a severe flag");
   write_no_set_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_addr == afe_pkg::OFF_ERR_FLAGS && !i_restart_request_bit && !i_trigger_bit
       && !i_result_store_fault && !i_fetch_out_of_range && !i_command_reserved
       && !i_resolution_reserved && !i_missing_end_of_list)
      |=> ((s_reg.err_flags & ~$past(s_reg.err_flags)) == afe_pkg::RESET_BYTE))
      else $error("write set an error flag");
   rstar_clear_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_addr == afe_pkg::OFF_ERR_FLAGS && i_wdata[afe_pkg::BIT_RSTAR]
       && !i_restart_request_bit) |=> !s_reg.err_flags[afe_pkg::BIT_RSTAR])
      else $error("restart error not cleared by write");
   err_ie_write_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_wr && i_addr == afe_pkg::OFF_ERR_IE)
      |=> (s_reg.err_ie == ($past(i_wdata) & afe_pkg::ERR_IE_MASK)))
      else $error("error enable register not written");
   abort_irq_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_abort_done && s_reg.ie[afe_pkg::BIT_ABORT_DONE_IE]
       && !(i_wr && i_addr == afe_pkg::OFF_IE)) |=> o_abort_done_irq)
      else $error("abort done interrupt not raised");
   overrun_irq_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_completion_overrun && s_reg.ie[afe_pkg::BIT_OVERRUN_IE]
       && !(i_wr && i_addr == afe_pkg::OFF_IE)) |=> o_overrun_irq)
      else $error("overrun interrupt not raised");
   restart_load_a: assert property (@(posedge i_mclk) disable iff (i_reset)
      (i_module_enable && !i_soft_reset_bit && !o_halted && i_restart_request_bit
       && !i_trigger_bit && !i_result_store_fault && !i_fetch_out_of_range
       && !i_command_reserved && !i_resolution_reserved && !i_missing_end_of_list)
      |=> (o_load_first_command && (o_swap_list == $past(i_load_ok_bit))))
      else $error("restart did not load the first command");
endmodule
`default_nettype wire

// *** verilog/afe_pkg.sv ***
// Constants for the converter error flag and flow control block
package afe_pkg;
   // Register offsets
   localparam logic [3:0] OFF_ERR_IE = 4'h6;
   localparam logic [3:0] OFF_IE = 4'h7;
   localparam logic [3:0] OFF_ERR_FLAGS = 4'h8;
   // Bit positions shared by error enable and error flag registers
   localparam int BIT_IA = 7;
   localparam int BIT_CMD = 6;
   localparam int BIT_EOL = 5;
   localparam int BIT_TRIGGER_BIT = 3;
   localparam int BIT_RSTAR = 2;
   localparam int BIT_LOAD_OK_BIT = 1;
   // Interrupt enable bits
   localparam int BIT_ABORT_DONE_IE = 7;
   localparam int BIT_OVERRUN_IE = 6;
   // Implemented bits, severe and clearable flag masks, reset value
   localparam logic [7:0] ERR_IE_MASK = 8'hEE;
   localparam logic [7:0] IE_MASK = 8'hC0;
   localparam logic [7:0] SEVERE_MASK = 8'hE8;
   localparam logic [7:0] CLEARABLE_MASK = 8'h06;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // Flow control mode
   typedef enum logic [0:0] {
      AFE_MODE_RESTART = 1'b0,
      AFE_MODE_TRIGGER = 1'b1
   } afe_mode_t;
   // Sequencer states
   typedef enum logic [1:0] {
      AFE_IDLE = 2'b00,
      AFE_LOAD = 2'b01,
      AFE_RUN = 2'b10,
      AFE_HALT = 2'b11
   } afe_state_t;
endpackage
